// [design/gauge_config_defines.svh]
`ifndef GAUGE_CONFIG_DEFINES_SVH
`define GAUGE_CONFIG_DEFINES_SVH
// ----------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------
`define ADDR_OPERATION_CONFIG 8'h00
`define ADDR_FLASH_OK_MV 8'h01
`define ADDR_SLEEP_MA 8'h02
`define ADDR_HIB_MA 8'h03
`define ADDR_HIB_MV 8'h04
`define ADDR_CONTROL 8'h05
`define ADDR_STATUS 8'h06
`define ADDR_USER_BASE 8'h10
`define USER_WORDS 12
// ----------------------------------------------------------------
// Operation configuration fields
// ----------------------------------------------------------------
`define OPC_RESERVE_COMPENSATION_ENABLE 15
`define OPC_MODE_HI 12
`define OPC_MODE_LO 11
`define OPC_WAKE_RANGE 10
`define OPC_SENSE_HI 9
`define OPC_SENSE_LO 8
`define OPC_PROFILE 6
`define OPC_SLEEP 5
`define OPC_FCC_UPD 4
`define OPC_LOWBAT_POL 3
`define OPC_BATGOOD_POL 2
`define OPC_TEMP_SRC 0
`define OPC_RESET 16'h0979
// ----------------------------------------------------------------
// Threshold reset values
// ----------------------------------------------------------------
`define FLASH_OK_MV_RESET 16'h0af0
`define SLEEP_MA_RESET 16'h000f
`define HIB_MA_RESET 16'h0008
`define HIB_MV_RESET 16'h09f6
// ----------------------------------------------------------------
// Calibration time before sleep
// ----------------------------------------------------------------
`define CAL_TIME_NS 1000
`define CLK_PERIOD_NS 5
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [design/gauge_config_pkg.sv]
`default_nettype none
package gauge_config_pkg;
	typedef enum logic [3:0] {
		PM_ACTIVE = 4'b0001,
		PM_CAL = 4'b0010,
		PM_SLEEP = 4'b0100,
		PM_HIBERNATE = 4'b1000
	} power_state_t;
	typedef enum logic [1:0] {
		CM_OPEN = 2'b00,
		CM_MONITOR = 2'b01,
		CM_SHARED = 2'b10
	} charger_mode_t;
	typedef enum logic [2:0] {
		WT_OFF = 3'd0,
		WT_1P25 = 3'd1,
		WT_2P5 = 3'd2,
		WT_5 = 3'd3,
		WT_10 = 3'd4
	} wake_thresh_t;
endpackage : gauge_config_pkg
`default_nettype wire

// [design/gauge_config_power_modes.sv]
// Functional notes
// R1 - Reserve compensation bit enables no-load compensation of reserve capacity; default zero.
// R2 - Bits 14, 13, 7 and 1 are reserved and have no function.
// R3 - Bits 12:11 choose charger mode 0, 1 or 2; default mode 1.
// R4 - Mode 0 measures temperature only in discharge and relaxation.
// R5 - Mode 1 also monitors charge temperature and disables charger when out of range.
// R6 - Mode 2 shares thermistor: charger during charge, gauge otherwise.
// R7 - In sleep or hibernate, wake comparator interrupts on threshold crossing either way.
// R8 - Sense-select and range bits decode wake threshold; sense 00 disables; default 001.
// R9 - Profile-select bit enables cell profile selection; default one.
// R10 - Sleep only when enabled and average current magnitude below sleep threshold.
// R11 - Run converter calibration before entering sleep.
// R12 - Full-capacity bit loads remaining capacity from full capacity on termination.
// R13 - Low-battery output active-high when polarity bit set; default one.
// R14 - Battery-good output active-low when polarity bit clear; default zero.
// R15 - Temperature source bit picks external thermistor when one, internal when zero.
// R16 - Refuse flash writes below flash voltage limit unless charger detected.
// R17 - Hibernate on request when average current magnitude below hibernate current limit.
// R18 - Hibernate on request when cell voltage below hibernate voltage limit.
// R19 - Three user string blocks of eight characters, default zeros.
// R20 - Charging means measured current above the charge current threshold.
// R21 - Reserved bits read back as written and affect nothing.
//
// The implementer's own choices: the strobed register port and the address map.
`include "gauge_config_defines.svh"
`default_nettype none
module gauge_config_power_modes #(
	parameter int CAL_CYCLES = `CAL_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic signed [15:0] current_ma_i,
	input wire logic signed [15:0] avg_current_ma_i,
	input wire logic [15:0] chg_threshold_ma_i,
	input wire logic [15:0] voltage_mv_i,
	input wire logic signed [15:0] sense_uv_i,
	input wire logic [15:0] ext_temp_i,
	input wire logic [15:0] int_temp_i,
	input wire logic temp_out_of_range_i,
	input wire logic low_battery_flag_i,
	input wire logic charger_detected_i,
	input wire logic termination_i,
	input wire logic [15:0] full_capacity_i,
	input wire logic flash_wr_req_i,
	output logic flash_wr_grant_o,
	output logic flash_wr_refused_o,
	output logic rem_cap_load_o,
	output logic [15:0] rem_cap_o,
	output logic reserve_comp_o,
	output logic profile_select_o,
	output logic [15:0] temperature_o,
	output logic temp_measure_en_o,
	output logic thermistor_to_charger_o,
	output logic battery_good_output_o,
	output logic low_battery_output_o,
	output logic adc_cal_o,
	output logic wake_irq_o,
	output logic [3:0] power_state_o
);
	import gauge_config_pkg::*;

	initial begin
		if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin
			$error("CAL_CYCLES out of range");
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] opc;
		logic [15:0] flash_mv;
		logic [15:0] sleep_ma;
		logic [15:0] hib_ma;
		logic [15:0] hib_mv;
		logic hib_req;
		logic [`USER_WORDS*16-1:0] user;
		power_state_t pstate;
		logic [15:0] cal_cnt;
		logic [15:0] rdata;
		logic [15:0] temp;
		logic [15:0] rem_cap;
		logic rem_load;
		logic grant;
		logic refused;
		logic wake_irq;
		logic above_prev;
		logic below_prev;
		logic temp_fault;
	} state_t;

	state_t s_reg;
	state_t s_next;

	charger_mode_t cmode;
	wake_thresh_t wsel;
	logic [15:0] wake_uv;
	logic charging;
	logic [15:0] avg_mag;
	logic sleep_ok;
	logic hib_ok;
	logic above;
	logic below;

	always_comb begin
		cmode = charger_mode_t'(s_reg.opc[`OPC_MODE_HI:`OPC_MODE_LO]); // [R3]
		charging = current_ma_i > $signed({1'b0, chg_threshold_ma_i[14:0]}); // [R20]
		avg_mag = avg_current_ma_i[15] ? 16'(-avg_current_ma_i) : avg_current_ma_i;
		sleep_ok = s_reg.opc[`OPC_SLEEP] && (avg_mag < s_reg.sleep_ma); // [R10]
		hib_ok = s_reg.hib_req && ((avg_mag < s_reg.hib_ma) || (voltage_mv_i < s_reg.hib_mv)); // [R17] [R18]
		// Threshold decoded from {sense_hi, sense_lo, range}.
		unique case ({s_reg.opc[`OPC_SENSE_HI], s_reg.opc[`OPC_SENSE_LO], s_reg.opc[`OPC_WAKE_RANGE]}) // [R8]
			3'h2: wsel = WT_1P25;
			3'h3, 3'h4: wsel = WT_2P5;
			3'h5, 3'h6: wsel = WT_5;
			3'h7: wsel = WT_10;
			default: wsel = WT_OFF;
		endcase
		unique case (wsel)
			WT_1P25: wake_uv = 16'h04e2;
			WT_2P5: wake_uv = 16'h09c4;
			WT_5: wake_uv = 16'h1388;
			WT_10: wake_uv = 16'h2710;
			default: wake_uv = 16'h0000;
		endcase
		above = sense_uv_i > $signed({1'b0, wake_uv[14:0]});
		below = sense_uv_i < -$signed({1'b0, wake_uv[14:0]});
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rem_load = 1'b0;
		s_next.grant = 1'b0;
		s_next.refused = 1'b0;
		s_next.wake_irq = 1'b0;
		s_next.rdata = 16'h0000;
		// All sixteen bits stored except at the control address (bit 0 only), reserved ones included; they feed no logic.
		if (wr_i) begin // [R2] [R21]
			unique case (addr_i)
				`ADDR_OPERATION_CONFIG: s_next.opc = wdata_i;
				`ADDR_FLASH_OK_MV: s_next.flash_mv = wdata_i;
				`ADDR_SLEEP_MA: s_next.sleep_ma = wdata_i;
				`ADDR_HIB_MA: s_next.hib_ma = wdata_i;
				`ADDR_HIB_MV: s_next.hib_mv = wdata_i;
				`ADDR_CONTROL: s_next.hib_req = wdata_i[0];
				default: begin
					if (addr_i >= `ADDR_USER_BASE && addr_i < `ADDR_USER_BASE + 8'(`USER_WORDS)) begin // [R19]
						s_next.user[(addr_i - `ADDR_USER_BASE) * 16 +: 16] = wdata_i;
					end
				end
			endcase
		end
		if (rd_i) begin
			unique case (addr_i)
				`ADDR_OPERATION_CONFIG: s_next.rdata = s_reg.opc;
				`ADDR_FLASH_OK_MV: s_next.rdata = s_reg.flash_mv;
				`ADDR_SLEEP_MA: s_next.rdata = s_reg.sleep_ma;
				`ADDR_HIB_MA: s_next.rdata = s_reg.hib_ma;
				`ADDR_HIB_MV: s_next.rdata = s_reg.hib_mv;
				`ADDR_CONTROL: s_next.rdata = {15'h0000, s_reg.hib_req};
				`ADDR_STATUS: s_next.rdata = {11'h000, s_reg.temp_fault, s_reg.pstate};
				default: begin
					if (addr_i >= `ADDR_USER_BASE && addr_i < `ADDR_USER_BASE + 8'(`USER_WORDS)) begin
						s_next.rdata = s_reg.user[(addr_i - `ADDR_USER_BASE) * 16 +: 16];
					end
				end
			endcase
		end
		// Temperature source and measurement window.
		if (temp_measure_en_o) begin
			s_next.temp = s_reg.opc[`OPC_TEMP_SRC] ? ext_temp_i : int_temp_i; // [R15]
		end
		// Fault latched only in monitor mode while charging; it clears on recovery.
		s_next.temp_fault = (cmode == CM_MONITOR) && charging && temp_out_of_range_i; // [R5]
		// Flash protection: a charger lifts the voltage floor.
		if (flash_wr_req_i) begin
			if (charger_detected_i || voltage_mv_i >= s_reg.flash_mv) begin // [R16]
				s_next.grant = 1'b1;
			end else begin
				s_next.refused = 1'b1;
			end
		end
		if (termination_i && s_reg.opc[`OPC_FCC_UPD]) begin // [R12]
			s_next.rem_cap = full_capacity_i;
			s_next.rem_load = 1'b1;
		end
		// Edge of the comparator so a steady offset raises one event, not a stream.
		s_next.above_prev = above;
		s_next.below_prev = below;
		// ----------------------------------------------------------------
		// Power mode sequencing
		// ----------------------------------------------------------------
		unique case (s_reg.pstate)
			PM_ACTIVE: begin
				if (hib_ok) begin
					s_next.pstate = PM_HIBERNATE;
				end else if (sleep_ok) begin
					s_next.pstate = PM_CAL; // [R11]
					s_next.cal_cnt = 16'(CAL_CYCLES - 1);
				end
			end
			PM_CAL: begin
				if (!sleep_ok) begin
					s_next.pstate = PM_ACTIVE;
				end else if (s_reg.cal_cnt == 16'h0000) begin
					s_next.pstate = PM_SLEEP; // [R10]
				end else begin
					s_next.cal_cnt = s_reg.cal_cnt - 16'h0001;
				end
			end
			PM_SLEEP, PM_HIBERNATE: begin
				if (wsel != WT_OFF && ((above && !s_reg.above_prev) || (below && !s_reg.below_prev))) begin // [R7]
					s_next.wake_irq = 1'b1;
					s_next.pstate = PM_ACTIVE;
				end else if (s_reg.pstate == PM_SLEEP && hib_ok) begin
					s_next.pstate = PM_HIBERNATE;
				end else if (s_reg.pstate == PM_SLEEP && !sleep_ok) begin
					s_next.pstate = PM_ACTIVE;
				end else if (s_reg.pstate == PM_HIBERNATE && !s_reg.hib_req) begin
					s_next.pstate = PM_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_reg <= '0;
			s_reg.opc <= `OPC_RESET;
			s_reg.flash_mv <= `FLASH_OK_MV_RESET;
			s_reg.sleep_ma <= `SLEEP_MA_RESET;
			s_reg.hib_ma <= `HIB_MA_RESET;
			s_reg.hib_mv <= `HIB_MV_RESET;
			s_reg.pstate <= PM_ACTIVE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Mode 0 and 1 measure in charge only when mode 1; mode 2 yields the thermistor while charging.
	assign temp_measure_en_o = !charging || (cmode == CM_MONITOR); // [R4] [R6]
	assign thermistor_to_charger_o = (cmode == CM_SHARED) && charging; // [R6]
	assign battery_good_output_o = s_reg.temp_fault ^ ~s_reg.opc[`OPC_BATGOOD_POL]; // [R14] [R5]
	assign low_battery_output_o = low_battery_flag_i ~^ s_reg.opc[`OPC_LOWBAT_POL]; // [R13]
	assign reserve_comp_o = s_reg.opc[`OPC_RESERVE_COMPENSATION_ENABLE]; // [R1]
	assign profile_select_o = s_reg.opc[`OPC_PROFILE]; // [R9]
	assign adc_cal_o = s_reg.pstate == PM_CAL; // [R11]
	assign rdata_o = s_reg.rdata;
	assign temperature_o = s_reg.temp;
	assign flash_wr_grant_o = s_reg.grant;
	assign flash_wr_refused_o = s_reg.refused;
	assign rem_cap_load_o = s_reg.rem_load;
	assign rem_cap_o = s_reg.rem_cap;
	assign wake_irq_o = s_reg.wake_irq;
	assign power_state_o = s_reg.pstate;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence cal_run_s;
		s_reg.pstate == PM_CAL;
	endsequence

	sleep_entry_a: assert property ($rose(s_reg.pstate == PM_SLEEP) |-> $past(s_reg.pstate) == PM_CAL) // [R11]
		else $error("sleep entered without calibration");
	sleep_cond_a: assert property (cal_run_s ##1 s_reg.pstate == PM_SLEEP |-> $past(sleep_ok)) // [R10]
		else $error("sleep entered without permission");
	hib_entry_a: assert property ($rose(s_reg.pstate == PM_HIBERNATE) |-> $past(hib_ok)) // [R17]
		else $error("hibernate entered without cause");
	flash_refuse_a: assert property (flash_wr_req_i && !charger_detected_i && voltage_mv_i < s_reg.flash_mv
		|=> flash_wr_refused_o && !flash_wr_grant_o) // [R16]
		else $error("low voltage flash write not refused");
	flash_charger_a: assert property (flash_wr_req_i && charger_detected_i |=> flash_wr_grant_o) // [R16]
		else $error("flash write refused with charger");
	fcc_load_a: assert property (termination_i && s_reg.opc[`OPC_FCC_UPD]
		|=> rem_cap_load_o && rem_cap_o == $past(full_capacity_i)) // [R12]
		else $error("remaining capacity not loaded");
	wake_off_a: assert property (wsel == WT_OFF |=> !wake_irq_o) // [R8]
		else $error("wake raised while disabled");
	wake_state_a: assert property (wake_irq_o |-> $past(s_reg.pstate) inside {PM_SLEEP, PM_HIBERNATE}) // [R7]
		else $error("wake raised while active");
	shared_a: assert property (cmode == CM_SHARED && charging |-> thermistor_to_charger_o && !temp_measure_en_o) // [R6]
		else $error("thermistor not yielded");
	batgood_a: assert property (cmode != CM_MONITOR ##1 1'b1
		|-> battery_good_output_o == !s_reg.opc[`OPC_BATGOOD_POL]) // [R14]
		else $error("battery good asserted outside monitor mode");

	// ----------------------------------------------------------------
	// Configuration and power checks
	// ----------------------------------------------------------------
	// These restate each rule, partly from the pins and the register copy and partly from the shared decodes such as charging, cmode, wsel and sleep_ok.
	sequence dozing_s;
		s_reg.pstate inside {PM_SLEEP, PM_HIBERNATE};
	endsequence

	sequence crossing_s;
		wsel != WT_OFF && ((above && !s_reg.above_prev) || (below && !s_reg.below_prev));
	endsequence

	opc_store_a: assert property (wr_i && addr_i == `ADDR_OPERATION_CONFIG // [R21] [R2]
		|=> s_reg.opc == $past(wdata_i))
		else $error("configuration word not stored as written");
	reserve_compensation_enable_a: assert property (wr_i && addr_i == `ADDR_OPERATION_CONFIG // [R1]
		|=> reserve_comp_o == $past(wdata_i[`OPC_RESERVE_COMPENSATION_ENABLE]))
		else $error("reserve compensation not following its bit");
	profile_a: assert property (wr_i && addr_i == `ADDR_OPERATION_CONFIG // [R9]
		|=> profile_select_o == $past(wdata_i[`OPC_PROFILE]))
		else $error("profile selection not following its bit");
	mode_share_a: assert property (wr_i && addr_i == `ADDR_OPERATION_CONFIG // [R3]
		&& wdata_i[`OPC_MODE_HI:`OPC_MODE_LO] == 2'b10 |=> cmode == CM_SHARED)
		else $error("charger mode 2 not decoded");
	lowbat_hi_a: assert property (low_battery_flag_i |-> low_battery_output_o == s_reg.opc[`OPC_LOWBAT_POL]) // [R13]
		else $error("low battery output wrong when flagged");
	lowbat_lo_a: assert property (!low_battery_flag_i |-> low_battery_output_o == !s_reg.opc[`OPC_LOWBAT_POL]) // [R13]
		else $error("low battery output wrong when clear");
	batgood_pol_a: assert property (s_reg.temp_fault |-> battery_good_output_o == s_reg.opc[`OPC_BATGOOD_POL]) // [R14]
		else $error("battery good output wrong polarity");
	temp_ext_a: assert property (temp_measure_en_o && s_reg.opc[`OPC_TEMP_SRC] // [R15]
		|=> temperature_o == $past(ext_temp_i))
		else $error("external temperature not taken");
	temp_int_a: assert property (temp_measure_en_o && !s_reg.opc[`OPC_TEMP_SRC] // [R15]
		|=> temperature_o == $past(int_temp_i))
		else $error("internal temperature not taken");
	open_mode_a: assert property (cmode == CM_OPEN && charging |-> !temp_measure_en_o && !thermistor_to_charger_o) // [R4]
		else $error("mode 0 measured while charging");
	idle_meas_a: assert property (!charging |-> temp_measure_en_o && !thermistor_to_charger_o) // [R20] [R6]
		else $error("gauge lost thermistor outside charge");
	monitor_a: assert property (cmode == CM_MONITOR |-> temp_measure_en_o && !thermistor_to_charger_o) // [R5]
		else $error("mode 1 stopped measuring");
	fault_set_a: assert property (cmode == CM_MONITOR && charging && temp_out_of_range_i // [R5]
		|=> s_reg.temp_fault)
		else $error("charge temperature fault missed");
	fault_clear_a: assert property (!temp_out_of_range_i |=> !s_reg.temp_fault) // [R5]
		else $error("fault held after recovery");
	wake_none_a: assert property ({s_reg.opc[`OPC_SENSE_HI], s_reg.opc[`OPC_SENSE_LO]} == 2'b00 // [R8]
		|-> wake_uv == 16'h0000)
		else $error("wake threshold set while disabled");
	wake_low_a: assert property ({s_reg.opc[`OPC_SENSE_HI], s_reg.opc[`OPC_SENSE_LO], s_reg.opc[`OPC_WAKE_RANGE]} // [R8]
		== 3'b010 |-> wake_uv == 16'h04e2)
		else $error("lowest wake threshold wrong");
	wake_top_a: assert property ({s_reg.opc[`OPC_SENSE_HI], s_reg.opc[`OPC_SENSE_LO], s_reg.opc[`OPC_WAKE_RANGE]} // [R8]
		== 3'b111 |-> wake_uv == 16'h2710)
		else $error("highest wake threshold wrong");
	wake_edge_a: assert property (dozing_s ##0 crossing_s |=> wake_irq_o && power_state_o == PM_ACTIVE) // [R7]
		else $error("threshold crossing did not wake");
	sleep_exit_a: assert property (s_reg.pstate == PM_SLEEP && !sleep_ok |=> power_state_o != PM_SLEEP) // [R10]
		else $error("sleep held without permission");
	cal_start_a: assert property (s_reg.pstate == PM_ACTIVE && sleep_ok && !hib_ok |=> adc_cal_o) // [R11]
		else $error("calibration not started");
	cal_bound_a: assert property (adc_cal_o |-> s_reg.cal_cnt < 16'(CAL_CYCLES)) // [R11]
		else $error("calibration count out of range");
	hib_volt_a: assert property (s_reg.pstate == PM_ACTIVE && s_reg.hib_req && voltage_mv_i < s_reg.hib_mv // [R18]
		|=> power_state_o == PM_HIBERNATE)
		else $error("low voltage hibernate missed");
	hib_curr_a: assert property (s_reg.pstate == PM_ACTIVE && s_reg.hib_req && avg_mag < s_reg.hib_ma // [R17]
		|=> power_state_o == PM_HIBERNATE)
		else $error("low current hibernate missed");
	user_read_a: assert property (rd_i && addr_i == `ADDR_USER_BASE // [R19]
		|=> rdata_o == $past(s_reg.user[15:0]))
		else $error("user word read wrong");
	flash_quiet_a: assert property (!flash_wr_req_i |=> !flash_wr_grant_o && !flash_wr_refused_o) // [R16]
		else $error("flash answer without request");
	fcc_off_a: assert property (!(termination_i && s_reg.opc[`OPC_FCC_UPD]) |=> !rem_cap_load_o) // [R12]
		else $error("capacity loaded without cause");
endmodule : gauge_config_power_modes
`default_nettype wire

// [dv/charger_model.sv]
`default_nettype none
// ----------------------------------------------------------------
// External charger beside the gauge
// ----------------------------------------------------------------
// The charger reacts one clock after its enable changes, like a real loop would.
module charger_model (
	input wire logic core_clk_i,
	input wire logic charge_en_i,
	input wire logic thermistor_to_charger_i,
	input wire logic battery_good_output_i,
	input wire logic battery_good_polarity_i,
	output logic signed [15:0] current_ma_o,
	output logic charger_detected_o,
	output logic charger_halted_o,
	output logic thermistor_used_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		current_ma_o = -16'sd200;
		charger_detected_o = 1'b0;
		charger_halted_o = 1'b0;
		thermistor_used_o = 1'b0;
	end
	always @(posedge core_clk_i) begin
		current_ma_o <= charge_en_i ? 16'sd500 : -16'sd200;
		charger_detected_o <= charge_en_i;
		charger_halted_o <= charge_en_i && (battery_good_output_i == battery_good_polarity_i);
		thermistor_used_o <= charge_en_i && thermistor_to_charger_i;
	end
endmodule : charger_model
`default_nettype wire

// [dv/testbench.sv]
`include "gauge_config_defines.svh"
`default_nettype none
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("Error at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import gauge_config_pkg::*;
	// ----------------------------------------------------------------
	// Signals, clock and partner
	// ----------------------------------------------------------------
	logic core_clk_i = 1'b0, resetn_i = 1'b0, wr = 1'b0, rd = 1'b0, oor = 1'b0, lowbat = 1'b0;
	logic term = 1'b0, freq = 1'b0, charge_en = 1'b0, bg_pol = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000, volt = 16'h0e10, v, rdata, rem_cap, temp;
	logic signed [15:0] avg = 16'sd100, sense = 16'sd0, cur;
	logic grant, refused, load, rcomp, prof, meas, to_chg, bgood, lowout, cal, irq, chg_det, halted, t_used;
	logic [3:0] pstate;
	int errors = 0;
	int samples_checked = 0;
	int irq_count = 0;
	int thr[6] = '{1250, 2500, 2500, 5000, 5000, 10000};
	bit saw_cal;
	always #2.5 core_clk_i = ~core_clk_i;
	always @(negedge core_clk_i) if (irq === 1'b1) irq_count++;
	charger_model u_charger_model (.core_clk_i(core_clk_i), .charge_en_i(charge_en),
		.thermistor_to_charger_i(to_chg), .battery_good_output_i(bgood), .battery_good_polarity_i(bg_pol),
		.current_ma_o(cur), .charger_detected_o(chg_det), .charger_halted_o(halted), .thermistor_used_o(t_used));
	gauge_config_power_modes #(.CAL_CYCLES(4)) u_gauge_config_power_modes (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.current_ma_i(cur), .avg_current_ma_i(avg), .chg_threshold_ma_i(16'h004b), .voltage_mv_i(volt),
		.sense_uv_i(sense), .ext_temp_i(16'h0123), .int_temp_i(16'h0456), .temp_out_of_range_i(oor),
		.low_battery_flag_i(lowbat), .charger_detected_i(chg_det), .termination_i(term),
		.full_capacity_i(16'h0500), .flash_wr_req_i(freq), .flash_wr_grant_o(grant),
		.flash_wr_refused_o(refused), .rem_cap_load_o(load), .rem_cap_o(rem_cap), .reserve_comp_o(rcomp),
		.profile_select_o(prof), .temperature_o(temp), .temp_measure_en_o(meas),
		.thermistor_to_charger_o(to_chg), .battery_good_output_o(bgood), .low_battery_output_o(lowout),
		.adc_cal_o(cal), .wake_irq_o(irq), .power_state_o(pstate));
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge core_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		@(negedge core_clk_i);
		`CHK(rdata, exp)
	endtask : rd_chk
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask : cycles
	// A pulse input is raised for exactly one sampling edge; the answer stands one cycle later.
	task automatic pulse(input bit is_term);
		@(posedge core_clk_i);
		if (is_term) begin
			term <= 1'b1;
		end else begin
			freq <= 1'b1;
		end
		@(posedge core_clk_i);
		term <= 1'b0;
		freq <= 1'b0;
		@(negedge core_clk_i);
	endtask : pulse
	task automatic wait_state(input logic [3:0] s);
		saw_cal = 0;
		for (int i = 0; i < 100 && pstate !== s; i++) begin
			@(negedge core_clk_i);
			if (cal === 1'b1) saw_cal = 1;
		end
		`CHK(pstate, s)
	endtask : wait_state
	task automatic test_done();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	initial begin
		#200000;
		errors++;
		test_done();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		int c0;
		logic [2:0] c;
		repeat (4) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		rd_chk(`ADDR_OPERATION_CONFIG, 16'h0979);
		rd_chk(`ADDR_FLASH_OK_MV, 16'h0af0);
		rd_chk(`ADDR_SLEEP_MA, 16'h000f);
		rd_chk(`ADDR_HIB_MA, 16'h0008);
		rd_chk(`ADDR_HIB_MV, 16'h09f6);
		for (int i = 0; i < 12; i++) rd_chk(`ADDR_USER_BASE + 8'(i), 16'h0000);
		wr_reg(8'h0a, 16'h5a5a);
		rd_chk(8'h0a, 16'h0000);
		wr_reg(`ADDR_USER_BASE + 8'h0b, 16'h4142);
		rd_chk(`ADDR_USER_BASE + 8'h0b, 16'h4142);
		`CHK({rcomp, prof}, 2'b01)
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h69fb);
		rd_chk(`ADDR_OPERATION_CONFIG, 16'h69fb);
		`CHK({rcomp, prof, pstate}, {2'b01, PM_ACTIVE})
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h8899);
		cycles(1);
		`CHK({rcomp, prof}, 2'b10)
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0939);
		lowbat <= 1'b1;
		cycles(2);
		`CHK(lowout, 1'b1)
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0931);
		cycles(2);
		`CHK(lowout, 1'b0)
		`CHK({meas, temp}, {1'b1, 16'h0123})
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0938);
		cycles(2);
		`CHK(temp, 16'h0456)
		for (int m = 0; m < 3; m++) begin
			wr_reg(`ADDR_OPERATION_CONFIG, 16'h0139 | 16'(m << 11));
			charge_en <= 1'b1;
			cycles(3);
			`CHK({meas, to_chg, t_used}, {m == 1, m == 2, m == 2})
			@(posedge core_clk_i);
			charge_en <= 1'b0;
			cycles(3);
			`CHK({meas, to_chg, t_used}, 3'b100)
		end
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0939);
		charge_en <= 1'b1;
		oor <= 1'b1;
		cycles(4);
		`CHK({bgood, halted}, 2'b01)
		rd_chk(`ADDR_STATUS, 16'h0011);
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h093d);
		bg_pol <= 1'b1;
		cycles(4);
		`CHK({bgood, halted}, 2'b11)
		oor <= 1'b0;
		cycles(4);
		`CHK({bgood, halted}, 2'b00)
		charge_en <= 1'b0;
		volt <= 16'd2799;
		cycles(3);
		pulse(1'b0);
		`CHK({grant, refused}, 2'b01)
		charge_en <= 1'b1;
		cycles(3);
		pulse(1'b0);
		`CHK({grant, refused}, 2'b10)
		charge_en <= 1'b0;
		volt <= 16'd2800;
		cycles(3);
		pulse(1'b0);
		`CHK({grant, refused}, 2'b10)
		pulse(1'b1);
		`CHK({load, rem_cap}, {1'b1, 16'h0500})
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0929);
		pulse(1'b1);
		`CHK(load, 1'b0)
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0919);
		avg <= -16'sd14;
		cycles(20);
		`CHK(pstate, PM_ACTIVE)
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			wr_reg(`ADDR_OPERATION_CONFIG, 16'h0839 | {5'h00, c[0], c[2:1], 8'h00});
			avg <= (c == 3'd0) ? 16'sd15 : -16'sd14;
			wait_state((c == 3'd0) ? PM_ACTIVE : PM_SLEEP);
			`CHK(saw_cal, c != 3'd0)
			c0 = irq_count;
			@(posedge core_clk_i);
			sense <= (c < 3'd2) ? 16'sd20000 : 16'(c[0] ? thr[c - 2] - 100 : 100 - thr[c - 2]);
			cycles(12);
			`CHK(irq_count, c0)
			sense <= (c < 3'd2) ? 16'sd0 : 16'(c[0] ? thr[c - 2] + 100 : -100 - thr[c - 2]);
			for (int i = 0; i < 50 && irq_count == c0 && c > 3'd1; i++) @(negedge core_clk_i);
			`CHK(irq_count, c0 + int'(c > 3'd1))
			@(posedge core_clk_i);
			sense <= 16'sd0;
			avg <= 16'sd100;
			cycles(12);
		end
		wr_reg(`ADDR_OPERATION_CONFIG, 16'h0919);
		volt <= 16'd2549;
		wr_reg(`ADDR_CONTROL, 16'h0001);
		wait_state(PM_HIBERNATE);
		rd_chk(`ADDR_CONTROL, 16'h0001);
		volt <= 16'd2550;
		avg <= -16'sd8;
		wr_reg(`ADDR_CONTROL, 16'h0000);
		wait_state(PM_ACTIVE);
		wr_reg(`ADDR_CONTROL, 16'h0001);
		cycles(10);
		`CHK(pstate, PM_ACTIVE)
		avg <= -16'sd7;
		wait_state(PM_HIBERNATE);
		wr_reg(`ADDR_CONTROL, 16'h0000);
		wait_state(PM_ACTIVE);
		test_done();
	end
endmodule : testbench
`default_nettype wire
